// [aic_regs.svh]
`ifndef AIC_REGS_SVH
`define AIC_REGS_SVH

`define AIC_OFS_GEN_INT_STATUS 16'h209c
`define AIC_OFS_POLARITY       16'h3000
`define AIC_OFS_CLEAR          16'h3004
`define AIC_OFS_SELECT0        16'h3008
`define AIC_OFS_SELECT1        16'h300c
`define AIC_OFS_FLAGS0         16'h3010
`define AIC_OFS_FLAGS1         16'h3014

`define AIC_RST_POLARITY       32'h0000_0000
`define AIC_RST_SELECT         32'h0000_2000
`define AIC_RST_FLAGS          32'h0000_0000
`define AIC_RST_GEN_INT_STATUS 32'h0000_0010

`define AIC_POL_BIT            0
`define AIC_CUSTOM_LSB         9
`define AIC_EXT_NUM            8

`endif

// [aic_pkg.sv]
package aic_pkg;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        from_seq;
    logic [15:0] addr;
    logic [31:0] wdata;
  } aic_req_t;

  typedef struct packed {
    logic [2:0] sel0;
    logic [1:0] sel1;
  } aic_route_t;

  typedef enum logic [2:0] {
    AIC_EXT_OFF     = 3'b000,
    AIC_EXT_RISE    = 3'b001,
    AIC_EXT_FALL    = 3'b010,
    AIC_EXT_BOTH    = 3'b011,
    AIC_EXT_HIGH    = 3'b100,
    AIC_EXT_LOW     = 3'b101
  } aic_ext_mode_t;

endpackage

// [aic_interrupt_controller.sv]
`timescale 1ns/10ps
`include "aic_regs.svh"

// Operation
// - two blocks, shared polarity and clear
// - enabled source event sets its flag
// - block0 to gpio 0/3/6, block1 4/7
// - software picks rising or falling output edge
// - polarity 0 falling, 1 rising
// - new interrupt toggles selected pin
// - host writes clear, device clears flag
// - clear acts only on ones
// - select bits 9..12 enable custom sources
// - writing one raises custom event
// - only sequencer writes reach custom status
// - eight external detectors, selectable modes
// - rising or falling edge gives pulse
// - either edge gives pulse on change
// - level modes hold while level present
// - external event wakes from hibernate
// - flags 0..8 measurement results
// - flags 13,15,16,17 sequencer events
// - flags 23..27 data fifo events
// - flag 29 outlier
// - flag 31 second sequence refused
// - flags read only, reset zero
// - select resets to boot done only
module aic_interrupt_controller
  import aic_pkg::*;
(
  input  wire logic             sys_clk_in,
  input  wire logic             srst_in,
  input  wire aic_req_t         req_in,
  output logic      [31:0]      rdata_out,
  output logic                  rvalid_out,
  input  wire logic [31:0]      event_in,
  input  wire logic             hibernate_in,
  input  wire logic [7:0]       ext_pin_in,
  input  wire aic_ext_mode_t [7:0] ext_mode_in,
  input  wire aic_route_t       route_in,
  output logic [7:0]            gpio_irq_out,
  output logic [7:0]            gpio_irq_en_n_out,
  output logic [7:0]            ext_irq_out,
  output logic                  wake_out
);

  logic [31:0] polarity_r;
  logic [31:0] select0_r;
  logic [31:0] select1_r;
  logic [31:0] flags0_r;
  logic [31:0] flags1_r;
  logic [31:0] gen_status_r;
  logic [31:0] custom_evt;
  logic [31:0] raw_evt;
  logic [31:0] clr_mask;
  logic [31:0] new0;
  logic [31:0] new1;
  logic        irq0_r;
  logic        irq1_r;
  logic [7:0]  ext_prev_r;
  logic [7:0]  ext_det;

  function automatic logic is_wr(input aic_req_t r, input logic [15:0] a);
    is_wr = r.wr && (r.addr == a);
  endfunction

  // Custom sources sit in bits 12:9; only sequencer writes count
  assign custom_evt = (is_wr(req_in, `AIC_OFS_GEN_INT_STATUS) &&
                       req_in.from_seq) ?
                      {19'h0, req_in.wdata[12:9], 9'h0} :
                      32'h0000_0000;
  // Bit map of sources follows event_in positions directly
  assign raw_evt  = (event_in & 32'hAF83_A1FF) |
                    custom_evt;
  assign clr_mask = is_wr(req_in, `AIC_OFS_CLEAR) ?
                    req_in.wdata : 32'h0000_0000;
  assign new0 = raw_evt & select0_r & ~flags0_r;
  assign new1 = raw_evt & select1_r & ~flags1_r;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      polarity_r <= `AIC_RST_POLARITY;
      select0_r  <= `AIC_RST_SELECT;
      select1_r  <= `AIC_RST_SELECT;
    end else if (req_in.wr) begin
      if (req_in.addr == `AIC_OFS_POLARITY) begin
        polarity_r <= {31'h0, req_in.wdata[`AIC_POL_BIT]};
      end
      if (req_in.addr == `AIC_OFS_SELECT0) begin
        select0_r <= req_in.wdata;
      end
      if (req_in.addr == `AIC_OFS_SELECT1) begin
        select1_r <= req_in.wdata;
      end
    end
  end

  // Set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      flags0_r <= `AIC_RST_FLAGS;
      flags1_r <= `AIC_RST_FLAGS;
    end else begin
      flags0_r <= (flags0_r & ~clr_mask) | (raw_evt & select0_r);
      flags1_r <= (flags1_r & ~clr_mask) | (raw_evt & select1_r);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      gen_status_r <= `AIC_RST_GEN_INT_STATUS;
    end else if (is_wr(req_in, `AIC_OFS_GEN_INT_STATUS) &&
                 req_in.from_seq) begin
      gen_status_r <= gen_status_r & ~req_in.wdata;
    end
  end

  // Idle level is opposite the active edge so the first event gives it
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      irq0_r <= 1'b1;
      irq1_r <= 1'b1;
    end else begin
      if (|new0) begin
        irq0_r <= ~irq0_r;
      end
      if (|new1) begin
        irq1_r <= ~irq1_r;
      end
    end
  end

  // A toggle always flips; polarity picks which phase is "idle"
  logic lvl0;
  logic lvl1;
  assign lvl0 = polarity_r[`AIC_POL_BIT] ? ~irq0_r : irq0_r;
  assign lvl1 = polarity_r[`AIC_POL_BIT] ? ~irq1_r : irq1_r;

  always_comb begin
    gpio_irq_en_n_out = 8'hFF;
    case (route_in.sel0)
      3'd1: gpio_irq_en_n_out[0] = 1'b0;
      3'd2: gpio_irq_en_n_out[3] = 1'b0;
      3'd3: gpio_irq_en_n_out[6] = 1'b0;
      default: ;
    endcase
    case (route_in.sel1)
      2'd1: gpio_irq_en_n_out[4] = 1'b0;
      2'd2: gpio_irq_en_n_out[7] = 1'b0;
      default: ;
    endcase
  end

  // Reset to the idle level so the host sees no false edge on release
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      gpio_irq_out <= 8'hD9;
    end else begin
      gpio_irq_out <= {lvl1, lvl0, 1'b0, lvl1, lvl0, 2'b00, lvl0};
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      ext_prev_r <= 8'h00;
    end else begin
      ext_prev_r <= ext_pin_in;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `AIC_EXT_NUM; gi++) begin : g_ext
      always_comb begin
        case (ext_mode_in[gi])
          AIC_EXT_RISE: ext_det[gi] = ext_pin_in[gi] & ~ext_prev_r[gi];
          AIC_EXT_FALL: ext_det[gi] = ~ext_pin_in[gi] & ext_prev_r[gi];
          AIC_EXT_BOTH: ext_det[gi] = ext_pin_in[gi] ^ ext_prev_r[gi];
          AIC_EXT_HIGH: ext_det[gi] = ext_pin_in[gi];
          AIC_EXT_LOW:  ext_det[gi] = ~ext_pin_in[gi];
          default:      ext_det[gi] = 1'b0;
        endcase
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      ext_irq_out <= 8'h00;
      wake_out    <= 1'b0;
    end else begin
      ext_irq_out <= ext_det;
      wake_out    <= hibernate_in & (|ext_det);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      rdata_out  <= 32'h0000_0000;
      rvalid_out <= 1'b0;
    end else begin
      rvalid_out <= req_in.rd;
      case (req_in.addr)
        `AIC_OFS_POLARITY:       rdata_out <= polarity_r;
        `AIC_OFS_SELECT0:        rdata_out <= select0_r;
        `AIC_OFS_SELECT1:        rdata_out <= select1_r;
        `AIC_OFS_FLAGS0:         rdata_out <= flags0_r;
        `AIC_OFS_FLAGS1:         rdata_out <= flags1_r;
        `AIC_OFS_GEN_INT_STATUS: rdata_out <= gen_status_r;
        default:                 rdata_out <= 32'h0000_0000;
      endcase
    end
  end

endmodule // aic_interrupt_controller

// [aic_interrupt_controller_assertions.sv]
`timescale 1ns/10ps
module aic_chk
  import aic_pkg::*;
(
  input wire logic                sys_clk_in,
  input wire logic                srst_in,
  input wire aic_req_t            req_in,
  input wire logic [31:0]         rdata_out,
  input wire logic                rvalid_out,
  input wire logic [31:0]         event_in,
  input wire logic                hibernate_in,
  input wire logic [7:0]          ext_pin_in,
  input wire aic_ext_mode_t [7:0] ext_mode_in,
  input wire aic_route_t          route_in,
  input wire logic [7:0]          gpio_irq_out,
  input wire logic [7:0]          gpio_irq_en_n_out,
  input wire logic [7:0]          ext_irq_out,
  input wire logic                wake_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  a_read_answered: assert property (req_in.rd |=> rvalid_out)
    else $error("read not answered");
  a_no_stray_valid: assert property (!req_in.rd |=> !rvalid_out)
    else $error("read valid without read");
  a_route_drives: assert property ((route_in.sel0 == 3'h1 &&
    route_in.sel1 == 2'h1) |-> !gpio_irq_en_n_out[0] && !gpio_irq_en_n_out[4])
    else $error("routed pin not driven");
  a_unrouted_off: assert property (gpio_irq_en_n_out[1] &&
    gpio_irq_en_n_out[2] && gpio_irq_en_n_out[5])
    else $error("unroutable pin driven");
  a_rise_pulse: assert property ((ext_mode_in[0] == AIC_EXT_RISE)
    ##0 $rose(ext_pin_in[0]) ##1 (ext_mode_in[0] == AIC_EXT_RISE)
    |-> ##[0:1] ext_irq_out[0]) else $error("rising edge missed");
  a_high_holds: assert property ((ext_mode_in[1] == AIC_EXT_HIGH
    && ext_pin_in[1])[*3] |-> ext_irq_out[1])
    else $error("high level not held");
  a_wake_gated: assert property (!$past(hibernate_in) |-> !wake_out)
    else $error("wake while awake");
  a_pin_quiet: assert property ((event_in == '0 && !req_in.wr)[*4]
    |=> $stable(gpio_irq_out)) else $error("pin moved without event");
endmodule // aic_chk
bind aic_interrupt_controller aic_chk u_aic_chk (.sys_clk_in, .srst_in,
  .req_in, .rdata_out, .rvalid_out, .event_in, .hibernate_in, .ext_pin_in,
  .ext_mode_in, .route_in, .gpio_irq_out, .gpio_irq_en_n_out, .ext_irq_out,
  .wake_out);

// [aic_host_model.sv]
`timescale 1ns/10ps
module aic_host_model (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       gpio_in,
  input  wire logic       en_n_in,
  input  wire logic       pol_in,
  output logic [7:0]      edges_out
);
  logic      line_r;
  // Pull-up holds the line when the pin is released
  wire logic pin = en_n_in ? 1'b1 : gpio_in;
  always_ff @(posedge clk_in) begin
    line_r <= pin;
    if (rst_in) edges_out <= 8'h00;
    else if (pol_in ? (pin && !line_r) : (!pin && line_r))
      edges_out <= edges_out + 8'h01;
  end
endmodule // aic_host_model

// [tb.sv]
`timescale 1ns/10ps
module tb;
  import aic_pkg::*;
  logic sys_clk_in = 0, srst_in = 1, hib = 0, pol = 0, rv, wake;
  aic_req_t req = '0;
  logic [31:0] ev = '0, rdata, sel, v, exp_q[$];
  logic [7:0] pins = '0, gpio, en_n, ext, edges;
  aic_ext_mode_t [7:0] mode;
  aic_route_t route = '{sel0: 3'h1, sel1: 2'h1};
  integer seed = 32'hc121_0e0f;
  int n_fail = 0, total_checks = 0;
  always #5 sys_clk_in = ~sys_clk_in;
  aic_interrupt_controller u_aic_interrupt_controller (.sys_clk_in,
    .srst_in, .req_in(req), .rdata_out(rdata), .rvalid_out(rv),
    .event_in(ev), .hibernate_in(hib), .ext_pin_in(pins), .ext_mode_in(mode),
    .route_in(route), .gpio_irq_out(gpio), .gpio_irq_en_n_out(en_n),
    .ext_irq_out(ext), .wake_out(wake));
  aic_host_model u_aic_host_model (.clk_in(sys_clk_in), .rst_in(srst_in),
    .gpio_in(gpio[0]), .en_n_in(en_n[0]), .pol_in(pol), .edges_out(edges));
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic s, input logic [15:0] a,
                     input logic [31:0] d);
    @(negedge sys_clk_in);
    req = '{wr: w, rd: !w, from_seq: s, addr: a, wdata: d};
    @(negedge sys_clk_in);
    req = '0;
  endtask
  // Extra idle cycle lets flag updates land before the read is taken
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    @(negedge sys_clk_in);
    exp_q.push_back(e);
    acc(0, 0, a, '0);
  endtask
  task automatic pulse(input logic [31:0] e);
    @(negedge sys_clk_in);
    ev = e;
    @(negedge sys_clk_in);
    ev = '0;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(negedge sys_clk_in) begin
    if (rv === 1'b1) chk(exp_q.pop_front(), rdata);
    if (!srst_in) {hib, pins} = 9'($random(seed));
  end
  initial begin
    #50000;
    n_fail++;
    summarize;
  end
  initial begin
    for (int i = 0; i < 8; i++) mode[i] = AIC_EXT_RISE;
    repeat (2) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    srst_in = 0;
    rd(16'h3008, 32'h0000_2000);
    rd(16'h300c, 32'h0000_2000);
    rd(16'h3010, 32'h0000_0000);
    rd(16'h3000, 32'h0000_0000);
    acc(1, 0, 16'h3008, 32'h0000_0201);
    pulse(32'h0000_0001);
    rd(16'h3010, 32'h0000_0001);
    rd(16'h3014, 32'h0000_0000);
    acc(1, 0, 16'h3010, 32'hffff_ffff);
    rd(16'h3010, 32'h0000_0001);
    acc(1, 0, 16'h3004, 32'hffff_fffe);
    rd(16'h3010, 32'h0000_0001);
    chk(32'h0000_0001, {24'h0, edges});
    acc(1, 0, 16'h3004, 32'h0000_0001);
    rd(16'h3010, 32'h0000_0000);
    acc(1, 0, 16'h209c, 32'h0000_0200);
    rd(16'h3010, 32'h0000_0000);
    acc(1, 1, 16'h209c, 32'h0000_0200);
    rd(16'h3010, 32'h0000_0200);
    rd(16'h3100, 32'h0000_0000);
    acc(1, 0, 16'h3000, 32'h0000_0001);
    pol = 1'b1;
    rd(16'h3000, 32'h0000_0001);
    for (int i = 0; i < 6; i++) begin
      sel = $random(seed);
      v = $random(seed);
      acc(1, 0, 16'h3008, sel);
      acc(1, 0, 16'h3004, 32'hffff_ffff);
      pulse(v);
      rd(16'h3010, v & sel & 32'haf83_a1ff);
      rd(16'h3014, v & 32'h0000_2000);
    end
    for (int m = 1; m < 6; m++) begin
      @(negedge sys_clk_in);
      for (int i = 0; i < 8; i++) mode[i] = aic_ext_mode_t'(m[2:0]);
      repeat (40) @(negedge sys_clk_in);
    end
    summarize;
  end
endmodule // tb
